/* include/timer_ctrl_pkg.sv */
// constants for the timer-one compare/capture mode and flag logic
package timer_ctrl_pkg;

	// ==========================================================
	// bus geometry
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;

	// ==========================================================
	// register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_FLAG_ENABLE = 16'h1048;
	localparam logic [ADDR_W-1:0] ADDR_MODE_PIN    = 16'h104C;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS  = 16'h1050;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR   = 16'h1054;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE  = 16'h1058;

	// ==========================================================
	// mode/pin control fields
	localparam int BIT_EDGE_DETECT_EN   = 0;
	localparam int BIT_EXT_RESET_EN     = 1;
	localparam int BIT_EDGE_POLARITY    = 2;
	localparam int BIT_EDGE_TOGGLE_EN   = 3;
	localparam int BIT_CMP_ONE_RESET_EN = 4;
	localparam int BIT_CMP_TWO_TOGGLE   = 5;
	localparam int BIT_CMP_ONE_TOGGLE   = 6;
	localparam int BIT_COUNTER_MODE     = 7;
	localparam logic [7:0] MODE_PIN_RESET = 8'h00;

	// ==========================================================
	// flag/enable register fields
	localparam int BIT_CMP_ONE_IEN  = 0;
	localparam int BIT_CMP_TWO_IEN  = 1;
	localparam int BIT_EDGE_IEN     = 2;
	localparam int BIT_CMP_ONE_FLAG = 5;
	localparam int BIT_CMP_TWO_FLAG = 6;
	localparam int BIT_EDGE_FLAG    = 7;

	// ==========================================================
	// event index inside the three-bit status/clear/enable layout
	localparam int EV_CMP_ONE = 0;
	localparam int EV_CMP_TWO = 1;
	localparam int EV_EDGE    = 2;
	localparam int EV_COUNT   = 3;
	localparam logic [EV_COUNT-1:0] EV_RESET = 3'h0;

	// counter mode encoding
	localparam logic MODE_DUAL_COMPARE = 1'b0;
	localparam logic MODE_CAPTURE      = 1'b1;
	// edge polarity encoding
	localparam logic POL_FALLING = 1'b0;
	localparam logic POL_RISING  = 1'b1;

endpackage

/* hw/timer_one_compare_capture_ctrl.sv */
// mode control, pin toggling and interrupt flags of timer one, APB slave
module timer_one_compare_capture_ctrl
	import timer_ctrl_pkg::*;
(
	input  wire  logic                              clock,
	input  wire  logic                              rstn,
	// apb slave
	input  wire  logic                              psel,
	input  wire  logic                              penable,
	input  wire  logic                              pwrite,
	input  wire  logic [timer_ctrl_pkg::ADDR_W-1:0] paddr,
	input  wire  logic [timer_ctrl_pkg::DATA_W-1:0] pwdata,
	input  wire  logic [3:0]                        pstrb,
	output logic                                    pready,
	output logic                                    pslverr,
	output logic [timer_ctrl_pkg::DATA_W-1:0]       prdata,
	// counter side
	input  wire  logic                              cmpOneEqual,
	input  wire  logic                              cmpTwoEqual,
	output logic                                    counterClearOnTick,
	output logic                                    counterResetPulse,
	output logic                                    captureStrobe,
	// pins
	input  wire  logic                              capture_reset_pin,
	input  wire  logic                              pulseOutTimerFunction,
	output logic                                    pulse_out_pin,
	// interrupt
	output logic                                    irq
);
	import timer_ctrl_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		logic [7:0]          modeCtrl;
		logic [EV_COUNT-1:0] flags;
		logic [EV_COUNT-1:0] intEnable;
		logic                primed;
		logic                prevPin;
		logic                prevCmpOne;
		logic                prevCmpTwo;
		logic                pulseOut;
		logic                capture;
		logic                extReset;
		logic                clearArm;
		logic [DATA_W-1:0]   rdata;
	} state_s;

	state_s stateReg;
	state_s stateNext;

	// ==========================================================
	// helpers

	// decode of one mapped word address
	function automatic logic addrHit(
		input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] target
	);
		addrHit = (addr == target);
	endfunction

	// true for any address that the block answers
	function automatic logic addrMapped(input logic [ADDR_W-1:0] addr);
		addrMapped = addrHit(addr, ADDR_FLAG_ENABLE) || addrHit(addr, ADDR_MODE_PIN)
			|| addrHit(addr, ADDR_IRQ_STATUS) || addrHit(addr, ADDR_IRQ_CLEAR)
			|| addrHit(addr, ADDR_IRQ_ENABLE);
	endfunction

	// flag/enable register image
	function automatic logic [7:0] flagImage(
		input logic [EV_COUNT-1:0] flg,
		input logic [EV_COUNT-1:0] ien
	);
		logic [7:0] img;
		img = 8'h00;
		img[BIT_CMP_ONE_FLAG] = flg[EV_CMP_ONE];
		img[BIT_CMP_TWO_FLAG] = flg[EV_CMP_TWO];
		img[BIT_EDGE_FLAG]    = flg[EV_EDGE];
		img[BIT_CMP_ONE_IEN]  = ien[EV_CMP_ONE];
		img[BIT_CMP_TWO_IEN]  = ien[EV_CMP_TWO];
		img[BIT_EDGE_IEN]     = ien[EV_EDGE];
		flagImage = img;
	endfunction

	// read image of one mapped word; unmapped and write-only words read zero
	function automatic logic [DATA_W-1:0] readWord(
		input logic [ADDR_W-1:0]   addr,
		input logic [7:0]          mode,
		input logic [EV_COUNT-1:0] flg,
		input logic [EV_COUNT-1:0] ien
	);
		logic [DATA_W-1:0] word;
		word = '0;
		case (addr)
			ADDR_FLAG_ENABLE: begin
				word[7:0] = flagImage(flg, ien);
			end
			ADDR_MODE_PIN: begin
				word[7:0] = mode;
			end
			ADDR_IRQ_STATUS: begin
				word[EV_COUNT-1:0] = flg;
			end
			ADDR_IRQ_ENABLE: begin
				word[EV_COUNT-1:0] = ien;
			end
			default: begin
				word = '0;
			end
		endcase
		readWord = word;
	endfunction

	// ==========================================================
	// combinational decode
	logic                accessPhase;
	logic                setupPhase;
	logic                wrFlag;
	logic                wrMode;
	logic                wrClear;
	logic                wrEnable;
	logic                captureMode;
	logic                busWrite;
	logic                detectArmed;
	logic                extResetEn;
	logic                risingSel;
	logic                edgeToggleEn;
	logic                cmpOneResetEn;
	logic                cmpTwoToggleEn;
	logic                cmpOneToggleEn;
	logic                pinEdge;
	logic                edgeValid;
	logic                cmpOneFirst;
	logic                cmpTwoFirst;
	logic                toggleReq;
	logic [EV_COUNT-1:0] evSet;
	logic [EV_COUNT-1:0] evClear;

	// bus phases; writes land only in the access cycle
	assign accessPhase = psel && penable;
	assign setupPhase  = psel && !penable;
	// only the low byte lane holds register bits; upper lanes alone write nothing
	assign busWrite = accessPhase && pwrite && pstrb[0];
	assign wrFlag   = busWrite && addrHit(paddr, ADDR_FLAG_ENABLE);
	assign wrMode   = busWrite && addrHit(paddr, ADDR_MODE_PIN);
	assign wrClear  = busWrite && addrHit(paddr, ADDR_IRQ_CLEAR);
	assign wrEnable = busWrite && addrHit(paddr, ADDR_IRQ_ENABLE);

	// ==========================================================
	// mode/pin control fields
	// reserved capture-mode bits keep their stored value but act on nothing
	assign captureMode    = (stateReg.modeCtrl[BIT_COUNTER_MODE] == MODE_CAPTURE);
	assign detectArmed    = stateReg.modeCtrl[BIT_EDGE_DETECT_EN];
	assign extResetEn     = stateReg.modeCtrl[BIT_EXT_RESET_EN];
	assign risingSel      = (stateReg.modeCtrl[BIT_EDGE_POLARITY] == POL_RISING);
	assign edgeToggleEn   = stateReg.modeCtrl[BIT_EDGE_TOGGLE_EN];
	assign cmpOneResetEn  = stateReg.modeCtrl[BIT_CMP_ONE_RESET_EN];
	assign cmpTwoToggleEn = stateReg.modeCtrl[BIT_CMP_TWO_TOGGLE];
	assign cmpOneToggleEn = stateReg.modeCtrl[BIT_CMP_ONE_TOGGLE];

	// edge of the chosen polarity; first cycle after reset only samples
	always_comb begin
		// primed stops the reset level of prevPin from faking an edge
		if (risingSel) begin
			pinEdge = stateReg.primed && !stateReg.prevPin && capture_reset_pin;
		end else begin
			pinEdge = stateReg.primed && stateReg.prevPin && !capture_reset_pin;
		end
	end

	// an edge counts only while detection or capture is enabled
	assign edgeValid = pinEdge && detectArmed;

	// "first equals": rising edge of the equality level
	assign cmpOneFirst = cmpOneEqual && !stateReg.prevCmpOne;
	assign cmpTwoFirst = cmpTwoEqual && !stateReg.prevCmpTwo;

	// several toggle causes in one cycle toggle the pin once only
	always_comb begin
		toggleReq = 1'b0;
		// compare one toggles in either mode
		if (cmpOneFirst && cmpOneToggleEn) begin
			toggleReq = 1'b1;
		end
		if (!captureMode && cmpTwoFirst && cmpTwoToggleEn) begin
			toggleReq = 1'b1;
		end
		if (!captureMode && edgeValid && edgeToggleEn) begin
			toggleReq = 1'b1;
		end
	end

	// event set terms
	always_comb begin
		evSet             = EV_RESET;
		evSet[EV_CMP_ONE] = cmpOneFirst;
		evSet[EV_CMP_TWO] = cmpTwoFirst && !captureMode;
		evSet[EV_EDGE]    = edgeValid;
	end

	// clear terms: zero in the flag register, or one in the clear register
	always_comb begin
		evClear = EV_RESET;
		if (wrFlag) begin
			evClear[EV_CMP_ONE] = !pwdata[BIT_CMP_ONE_FLAG];
			evClear[EV_CMP_TWO] = !pwdata[BIT_CMP_TWO_FLAG];
			evClear[EV_EDGE]    = !pwdata[BIT_EDGE_FLAG];
		end
		if (wrClear) begin
			evClear = evClear | pwdata[EV_COUNT-1:0];
		end
	end

	// ==========================================================
	// per-event sticky flags and interrupt terms
	logic [EV_COUNT-1:0] flagNext;
	logic [EV_COUNT-1:0] irqTerm;
	genvar ev;
	generate
		for (ev = 0; ev < EV_COUNT; ev++) begin : g_flag
			// a same-cycle event keeps the flag, so a clearing write cannot lose it
			assign flagNext[ev] = evSet[ev] || (stateReg.flags[ev] && !evClear[ev]);
			assign irqTerm[ev]  = stateReg.flags[ev] && stateReg.intEnable[ev];
		end
	endgenerate

	// ==========================================================
	// next-state logic
	always_comb begin
		stateNext = stateReg;

		// pin and match history
		stateNext.primed     = 1'b1;
		stateNext.prevPin    = capture_reset_pin;
		stateNext.prevCmpOne = cmpOneEqual;
		stateNext.prevCmpTwo = cmpTwoEqual;

		// mode register, all bits writable
		if (wrMode) begin
			stateNext.modeCtrl = pwdata[7:0];
		end

		// one-shot arm drops after its edge in dual mode; a write in the
		// same cycle loses so the seen edge is not re-armed silently
		if (edgeValid && !captureMode) begin
			stateNext.modeCtrl[BIT_EDGE_DETECT_EN] = 1'b0;
		end

		// interrupt enables, reachable from two addresses
		if (wrFlag) begin
			stateNext.intEnable[EV_CMP_ONE] = pwdata[BIT_CMP_ONE_IEN];
			stateNext.intEnable[EV_CMP_TWO] = pwdata[BIT_CMP_TWO_IEN];
			stateNext.intEnable[EV_EDGE]    = pwdata[BIT_EDGE_IEN];
		end
		if (wrEnable) begin
			stateNext.intEnable = pwdata[EV_COUNT-1:0];
		end

		// sticky flags: set wins over clear
		stateNext.flags = flagNext;

		// counter side strobes
		stateNext.capture  = captureMode && edgeValid;
		stateNext.extReset = !captureMode && edgeValid && extResetEn;
		stateNext.clearArm = cmpOneEqual && cmpOneResetEn;

		// pulse output only moves while the pin serves the timer
		if (toggleReq && pulseOutTimerFunction) begin
			stateNext.pulseOut = !stateReg.pulseOut;
		end

		// read data captured in the setup cycle, shown in the access cycle
		if (setupPhase && !pwrite) begin
			stateNext.rdata = readWord(paddr, stateReg.modeCtrl, stateReg.flags,
				stateReg.intEnable);
		end
	end

	// ==========================================================
	// state register, synchronous reset
	always_ff @(posedge clock) begin
		if (!rstn) begin
			stateReg.modeCtrl   <= MODE_PIN_RESET;
			stateReg.flags      <= EV_RESET;
			stateReg.intEnable  <= EV_RESET;
			stateReg.primed     <= 1'b0;
			stateReg.prevPin    <= 1'b0;
			stateReg.prevCmpOne <= 1'b0;
			stateReg.prevCmpTwo <= 1'b0;
			stateReg.pulseOut   <= 1'b0;
			stateReg.capture    <= 1'b0;
			stateReg.extReset   <= 1'b0;
			stateReg.clearArm   <= 1'b0;
			stateReg.rdata      <= '0;
		end else begin
			stateReg <= stateNext;
		end
	end

	// ==========================================================
	// outputs

	// zero wait states; unmapped addresses answer with an error
	assign pready  = 1'b1;
	assign pslverr = accessPhase && !addrMapped(paddr);
	assign prdata  = stateReg.rdata;

	// counter controls, all from flip-flops
	assign counterClearOnTick = stateReg.clearArm;
	assign counterResetPulse  = stateReg.extReset;
	assign captureStrobe      = stateReg.capture;
	assign pulse_out_pin      = stateReg.pulseOut;

	// level interrupt, drops as soon as flag or enable clears
	assign irq = |irqTerm;

	// ==========================================================
	// limitations
	// pslverr answers unmapped words only; a write to status is dropped quietly
	// reserved capture-mode bits read back what was last written
	// compare flags follow the rising edge of the equality level only,
	// so a match held across a clear does not set its flag again
	// toggles need the pin in its timer function, else the level stays put
	// one-shot detection must be re-armed by software after every edge in dual-compare mode; capture mode keeps it armed
	// capture and reset strobes last one cycle, the clear follows the match level; the counter must sample every cycle

endmodule

/* tb/pin_partner.sv */
// far-side model: drives the capture/reset pin and loads the pulse output
module pin_partner (
	input  wire logic clock,
	input  wire logic want,
	input  wire logic pulse_out_pin,
	output logic      capture_reset_pin,
	output int        toggles
);
	timeunit 1ns;
	timeprecision 1ps;
	logic lastOut  = 1'h0;
	logic pinLevel = 1'h0;
	int   count    = 0;
	// one driver per output
	assign capture_reset_pin = pinLevel;
	assign toggles           = count;
	// =====================================
	// pin launches after an edge, load counts every level change it sees
	always @(posedge clock) begin
		pinLevel <= want;
		if (pulse_out_pin !== lastOut)
			count <= count + 1;
		lastOut <= pulse_out_pin;
	end
endmodule

/* tb/timer_ctrl_props.sv */
// port-level assertions for the timer-one mode and flag block
module timer_ctrl_props (
	input wire logic clock,
	input wire logic rstn,
	input wire logic capture_reset_pin,
	input wire logic cmpOneEqual,
	input wire logic cmpTwoEqual,
	input wire logic pulseOutTimerFunction,
	input wire logic counterClearOnTick,
	input wire logic counterResetPulse,
	input wire logic captureStrobe,
	input wire logic pulse_out_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rstn);
	// =====================================
	// pin moved across the two edges before the strobe
	sequence s_pinMoved;
		$past(capture_reset_pin) != $past(capture_reset_pin, 2);
	endsequence
	property p_capCause;
		captureStrobe |-> s_pinMoved;
	endproperty
	a_capCause: assert property (p_capCause) else $error("capture without pin edge");
	property p_capPulse;
		captureStrobe |=> !captureStrobe;
	endproperty
	a_capPulse: assert property (p_capPulse) else $error("capture strobe too long");
	property p_rstCause;
		counterResetPulse |-> s_pinMoved;
	endproperty
	a_rstCause: assert property (p_rstCause) else $error("reset without pin edge");
	// detection disarms itself, so never two resets in a row
	property p_rstPulse;
		counterResetPulse |=> !counterResetPulse;
	endproperty
	a_rstPulse: assert property (p_rstPulse) else $error("reset pulse repeated");
	property p_modeExcl;
		!(captureStrobe && counterResetPulse);
	endproperty
	a_modeExcl: assert property (p_modeExcl) else $error("capture and reset together");
	property p_clearTick;
		counterClearOnTick |-> $past(cmpOneEqual);
	endproperty
	a_clearTick: assert property (p_clearTick) else $error("clear without match");
	// past rstn guard: reset itself drops the output level
	property p_toggleGate;
		$changed(pulse_out_pin) && $past(rstn) |-> $past(pulseOutTimerFunction);
	endproperty
	a_toggleGate: assert property (p_toggleGate) else $error("toggle while pin not timer");
	property p_toggleCause;
		$changed(pulse_out_pin) && $past(rstn) |-> $past(cmpOneEqual || cmpTwoEqual)
			|| ($past(capture_reset_pin) != $past(capture_reset_pin, 2));
	endproperty
	a_toggleCause: assert property (p_toggleCause) else $error("toggle without cause");
endmodule
bind timer_one_compare_capture_ctrl timer_ctrl_props chk (.clock, .rstn, .capture_reset_pin,
	.cmpOneEqual, .cmpTwoEqual, .pulseOutTimerFunction, .counterClearOnTick,
	.counterResetPulse, .captureStrobe, .pulse_out_pin);

/* tb/testbench.sv */
// self-checking bench for the timer-one mode and flag block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import timer_ctrl_pkg::*;
	logic              clock = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [ADDR_W-1:0] paddr = 16'h0;
	logic [DATA_W-1:0] pwdata = 32'h0, prdata;
	logic              cmpOneEqual = 1'h0, cmpTwoEqual = 1'h0, want = 1'h0;
	logic              pulseOutTimerFunction = 1'h1;
	logic              pready, pslverr, counterClearOnTick, counterResetPulse, captureStrobe;
	logic              capture_reset_pin, pulse_out_pin, irq;
	int                n_fail = 0, checked = 0, nRst = 0, nCap = 0, toggles;
	always #2 clock = ~clock;
	timer_one_compare_capture_ctrl uut (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'hF), .pready, .pslverr, .prdata, .cmpOneEqual, .cmpTwoEqual,
		.counterClearOnTick, .counterResetPulse, .captureStrobe, .capture_reset_pin,
		.pulseOutTimerFunction, .pulse_out_pin, .irq);
	pin_partner far (.clock, .want, .pulse_out_pin, .capture_reset_pin, .toggles);
	// =====================================
	// strobe counters: counts avoid guessing the exact strobe cycle
	always @(posedge clock) begin
		if (counterResetPulse === 1'h1)
			nRst <= nRst + 1;
		if (captureStrobe === 1'h1)
			nCap <= nCap + 1;
	end
	task final_report;
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer, request held until pready is seen
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int i;
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (pready !== 1'h1 && i < 16);
		if (i >= 16) begin
			n_fail++;
			final_report();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'h1, a, d, r, e);
	endtask
	task rd(input logic [15:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'h0, a, 32'h0, r, e);
		cmp(r, x);
	endtask
	task pinTo(input logic v);
		@(posedge clock);
		want <= v;
		repeat (4) @(posedge clock);
	endtask
	task eq(input logic two);
		@(posedge clock);
		if (two)
			cmpTwoEqual <= 1'h1;
		else
			cmpOneEqual <= 1'h1;
		repeat (2) @(posedge clock);
		cmpTwoEqual <= 1'h0;
		cmpOneEqual <= 1'h0;
		repeat (3) @(posedge clock);
	endtask
	task chkIrq(input logic x);
		@(negedge clock);
		cmp(irq, x);
	endtask
	// =====================================
	// scenarios
	task t_regs;
		logic [31:0] r;
		logic        e;
		rd(ADDR_MODE_PIN, 32'h0);
		wr(ADDR_MODE_PIN, 32'h5A);
		rd(ADDR_MODE_PIN, 32'h5A);
		wr(ADDR_MODE_PIN, 32'h0);
		apb(1'h0, 16'h1060, 32'h0, r, e);
		cmp({r[30:0], e}, 32'h1);
		$display("regs done");
	endtask
	// match held across a clear must not set the flag again
	task t_flags;
		wr(ADDR_IRQ_ENABLE, 32'h7);
		cmpOneEqual <= 1'h1;
		rd(ADDR_FLAG_ENABLE, 32'h27);
		chkIrq(1'h1);
		wr(ADDR_FLAG_ENABLE, 32'h07);
		rd(ADDR_FLAG_ENABLE, 32'h07);
		chkIrq(1'h0);
		eq(1'h1);
		rd(ADDR_IRQ_STATUS, 32'h2);
		wr(ADDR_IRQ_ENABLE, 32'h0);
		chkIrq(1'h0);
		wr(ADDR_FLAG_ENABLE, 32'hE0);
		rd(ADDR_FLAG_ENABLE, 32'h40);
		wr(ADDR_IRQ_CLEAR, 32'h2);
		rd(ADDR_IRQ_STATUS, 32'h0);
		$display("flags done");
	endtask
	task t_edge;
		int r0, g0;
		r0 = nRst;
		g0 = toggles;
		pinTo(1'h1);
		wr(ADDR_MODE_PIN, 32'h0F);
		pinTo(1'h0);
		cmp(nRst - r0, 0);
		pinTo(1'h1);
		cmp(nRst - r0, 1);
		cmp(toggles - g0, 1);
		rd(ADDR_MODE_PIN, 32'h0E);
		rd(ADDR_FLAG_ENABLE, 32'h80);
		wr(ADDR_MODE_PIN, 32'h03);
		pinTo(1'h0);
		cmp(nRst - r0, 2);
		cmp(toggles - g0, 1);
		wr(ADDR_FLAG_ENABLE, 32'h0);
		$display("edge done");
	endtask
	task t_cap;
		int c0, r0, g0;
		c0 = nCap;
		r0 = nRst;
		g0 = toggles;
		wr(ADDR_MODE_PIN, 32'h87);
		pinTo(1'h1);
		pinTo(1'h0);
		pinTo(1'h1);
		cmp(nCap - c0, 2);
		cmp(nRst - r0, 0);
		rd(ADDR_MODE_PIN, 32'h87);
		wr(ADDR_MODE_PIN, 32'hE0);
		eq(1'h1);
		eq(1'h0);
		cmp(toggles - g0, 1);
		wr(ADDR_MODE_PIN, 32'h60);
		eq(1'h1);
		cmp(toggles - g0, 2);
		pulseOutTimerFunction <= 1'h0;
		eq(1'h0);
		cmp(toggles - g0, 2);
		pulseOutTimerFunction <= 1'h1;
		wr(ADDR_MODE_PIN, 32'h10);
		cmpOneEqual <= 1'h1;
		repeat (3) @(posedge clock);
		cmp(counterClearOnTick, 1'h1);
		cmpOneEqual <= 1'h0;
		$display("capture done");
	endtask
	initial begin
		repeat (4) @(posedge clock);
		rstn <= 1'h1;
		t_regs();
		t_flags();
		t_edge();
		t_cap();
		final_report();
	end
endmodule
